// ==== rtl/csf_core.sv ====
/*
  csf_core: condition flag generation for an 8-bit core plus operand-range
  checking and effective-address forming for each addressing mode.
  assumes a single 100 MHz clock; instruction decode drives op/operand ports
  one operation per cycle; registers also reachable over APB.
*/
`timescale 1ns/1ns
module csf_core (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic op_valid_i,
  input wire logic [4:0] op_code_i,
  input wire logic [7:0] op_a_i,
  input wire logic [7:0] op_b_i,
  output logic [7:0] result_o,
  output logic [3:0] jump_flags_o,
  input wire logic mode_valid_i,
  input wire logic [2:0] mode_i,
  input wire logic [12:0] mode_field_i,
  input wire logic [15:0] mode_reg_val_i,
  input wire logic [12:0] next_pc_i,
  input wire logic rel_i,
  output logic [12:0] eff_addr_o,
  output logic mode_err_o
);
  // every check in this block lives in the one clock domain
  default clocking chk_cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  logic [7:0] result_r;
  logic [12:0] eff_r;
  logic err_r;
  logic [31:0] opnd_cfg_r;
  logic [7:0] res;
  logic [8:0] wide;
  logic v_n;
  logic s_n;
  logic z_n;
  logic c_n;
  logic upd_v;
  logic upd_szc;
  logic upd_z;
  logic upd_c;
  csf_pkg::csf_op_e op;
  assign op = csf_pkg::csf_op_e'(op_code_i);

  wire logic cin = flags_r[csf_pkg::C_BIT];
  wire logic [8:0] sum_w = {1'b0, op_a_i} + {1'b0, op_b_i};
  wire logic [8:0] sumc_w = sum_w + {8'h00, cin};
  wire logic [8:0] dif_w = {1'b0, op_a_i} - {1'b0, op_b_i};
  wire logic [8:0] difc_w = dif_w - {8'h00, cin};
  wire logic [7:0] mask_w = op_a_i & op_b_i;
  wire logic [7:0] imask_w = ~op_a_i & op_b_i;

  // flag combinations computed together so each bit has one source
  always_comb begin
    res = op_a_i;
    wide = 9'h000;
    v_n = 1'b0;
    c_n = cin;
    upd_v = 1'b0;
    upd_szc = 1'b0;
    upd_z = 1'b0;
    upd_c = 1'b0;
    case (op)
      csf_pkg::add_op, csf_pkg::adc_op: begin
        wide = (op == csf_pkg::adc_op) ? sumc_w : sum_w;
        res = wide[7:0];
        v_n = (op_a_i[7] == op_b_i[7]) && (res[7] != op_a_i[7]);
        c_n = wide[8];
        {upd_v, upd_szc, upd_z, upd_c} = 4'hF;
      end
      csf_pkg::sub_op, csf_pkg::sbc_op, csf_pkg::cp_op: begin
        wide = (op == csf_pkg::sbc_op) ? difc_w : dif_w;
        res = wide[7:0];
        v_n = (op_a_i[7] != op_b_i[7]) && (res[7] != op_a_i[7]);
        c_n = wide[8];
        {upd_v, upd_szc, upd_z, upd_c} = 4'hF;
      end
      csf_pkg::inc_op, csf_pkg::dec_op: begin
        res = (op == csf_pkg::inc_op) ? op_a_i + 8'h01 : op_a_i - 8'h01;
        v_n = (op == csf_pkg::inc_op) ? (op_a_i == 8'h7F)
                                      : (op_a_i == 8'h80);
        {upd_v, upd_szc, upd_z} = 3'h7;
      end
      csf_pkg::and_op, csf_pkg::or_op, csf_pkg::xor_op, csf_pkg::com_op:
      begin
        case (op)
          csf_pkg::and_op: res = op_a_i & op_b_i;
          csf_pkg::or_op: res = op_a_i | op_b_i;
          csf_pkg::xor_op: res = op_a_i ^ op_b_i;
          default: res = ~op_a_i;
        endcase
        v_n = 1'b0;
        {upd_v, upd_szc, upd_z} = 3'h7;
      end
      csf_pkg::test_under_mask_op, csf_pkg::test_inverse_mask_op: begin
        // destination is left alone; only flags reflect the test
        res = (op == csf_pkg::test_under_mask_op) ? mask_w : imask_w;
        v_n = 1'b0;
        {upd_v, upd_szc, upd_z} = 3'h7;
      end
      csf_pkg::rotate_left_op: begin
        res = {op_a_i[6:0], op_a_i[7]};
        c_n = op_a_i[7];
        v_n = res[7] ^ op_a_i[7];
        {upd_v, upd_szc, upd_z, upd_c} = 4'hF;
      end
      csf_pkg::rotate_right_op: begin
        res = {op_a_i[0], op_a_i[7:1]};
        c_n = op_a_i[0];
        v_n = res[7] ^ op_a_i[7];
        {upd_v, upd_szc, upd_z, upd_c} = 4'hF;
      end
      csf_pkg::rotate_left_via_carry_op: begin
        res = {op_a_i[6:0], cin};
        c_n = op_a_i[7];
        v_n = res[7] ^ op_a_i[7];
        {upd_v, upd_szc, upd_z, upd_c} = 4'hF;
      end
      csf_pkg::rotate_right_via_carry_op: begin
        res = {cin, op_a_i[7:1]};
        c_n = op_a_i[0];
        v_n = res[7] ^ op_a_i[7];
        {upd_v, upd_szc, upd_z, upd_c} = 4'hF;
      end
      csf_pkg::arith_right_shift_op: begin
        res = {op_a_i[7], op_a_i[7:1]};
        c_n = op_a_i[0];
        v_n = 1'b0;
        {upd_v, upd_szc, upd_z, upd_c} = 4'hF;
      end
      csf_pkg::set_carry_op: begin
        c_n = 1'b1;
        upd_c = 1'b1;
      end
      csf_pkg::clear_carry_op: begin
        c_n = 1'b0;
        upd_c = 1'b1;
      end
      csf_pkg::invert_carry_op: begin
        c_n = ~cin;
        upd_c = 1'b1;
      end
      default: res = op_a_i;
    endcase
  end
  assign s_n = res[7];
  assign z_n = (res == 8'h00);

  // apb decode; flag update beats a same-cycle bus write (undefined case)
  wire logic apb_wr = psel_i & penable_i & pwrite_i;
  wire logic flags_sel = (paddr_i == csf_pkg::FLAGS_ADDR);
  wire logic cfg_sel = (paddr_i == csf_pkg::OPND_ADDR);
  wire logic stat_sel = (paddr_i == csf_pkg::STAT_ADDR);
  wire logic ores_sel = (paddr_i == csf_pkg::OPND_RES_ADDR);
  wire logic mapped = flags_sel | cfg_sel | stat_sel | ores_sel;
  wire logic load_wr = op_valid_i && (op == csf_pkg::load_op);
  wire logic flag_op = op_valid_i && !load_wr;
  // compare, bit tests and carry ops leave the destination untouched
  wire logic res_wr = flag_op && !(op inside {csf_pkg::cp_op,
    csf_pkg::test_under_mask_op, csf_pkg::test_inverse_mask_op,
    csf_pkg::set_carry_op, csf_pkg::clear_carry_op,
    csf_pkg::invert_carry_op});

  always_comb begin
    flags_nxt = flags_r;
    if (apb_wr && flags_sel) begin
      flags_nxt = pwdata_i[7:0];
    end
    if (load_wr) begin
      flags_nxt = op_b_i;
    end
    if (flag_op) begin
      if (upd_v) flags_nxt[csf_pkg::V_BIT] = v_n;
      if (upd_szc) flags_nxt[csf_pkg::S_BIT] = s_n;
      if (upd_z) flags_nxt[csf_pkg::Z_BIT] = z_n;
      if (upd_c) flags_nxt[csf_pkg::C_BIT] = c_n;
    end
  end

  // operand range check and address forming
  logic [12:0] eff_n;
  logic err_n;
  wire logic [7:0] reg_lo = mode_field_i[7:0];
  wire logic [12:0] pair_val = mode_reg_val_i[12:0];
  wire logic [12:0] sdisp = {{5{mode_field_i[7]}}, mode_field_i[7:0]};
  wire logic pair_odd = mode_field_i[0];
  always_comb begin
    eff_n = 13'h0000;
    err_n = 1'b0;
    if (rel_i) begin
      eff_n = next_pc_i + sdisp;
      err_n = (mode_field_i[12:8] != 5'h00);
    end else begin
      case (csf_pkg::csf_mode_e'(mode_i))
        csf_pkg::reg_mode: begin
          eff_n = {5'h00, reg_lo};
          err_n = (mode_field_i[12:8] != 5'h00);
        end
        csf_pkg::work_reg_mode: begin
          eff_n = {9'h000, mode_field_i[3:0]};
          err_n = (mode_field_i[12:4] != 9'h000);
        end
        csf_pkg::reg_pair_mode: begin
          eff_n = {5'h00, reg_lo};
          err_n = pair_odd || (mode_field_i[12:8] != 5'h00);
        end
        csf_pkg::work_pair_mode: begin
          eff_n = pair_val;
          err_n = pair_odd || (mode_field_i[12:4] != 9'h000);
        end
        csf_pkg::indexed_mode: begin
          eff_n = {5'h00, reg_lo + mode_reg_val_i[7:0]};
          err_n = (mode_field_i[12:8] != 5'h00);
        end
        csf_pkg::short_index_mode: begin
          eff_n = pair_val + sdisp;
          err_n = (mode_field_i[12:8] != 5'h00) || mode_reg_val_i[15];
        end
        csf_pkg::long_index_mode: begin
          eff_n = pair_val + mode_field_i;
          err_n = mode_reg_val_i[15];
        end
        csf_pkg::direct_target_mode: begin
          eff_n = mode_field_i;
          err_n = (mode_field_i > csf_pkg::ADDR_MAX);
        end
        default: err_n = 1'b1;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flags_r <= csf_pkg::FLAGS_RST;
      result_r <= 8'h00;
      eff_r <= 13'h0000;
      err_r <= 1'b0;
      opnd_cfg_r <= 32'h0000_0000;
    end else begin
      flags_r <= flags_nxt;
      if (res_wr) result_r <= res;
      if (mode_valid_i) eff_r <= eff_n;
      if (mode_valid_i) err_r <= err_n;
      if (apb_wr && cfg_sel) opnd_cfg_r <= pwdata_i;
    end
  end

  assign result_o = result_r;
  assign jump_flags_o = flags_r[csf_pkg::C_BIT:csf_pkg::V_BIT];
  assign eff_addr_o = eff_r;
  assign mode_err_o = err_r;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~mapped;

  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h0000_0000;
    if (flags_sel) rdata = {24'h000000, flags_r};
    if (cfg_sel) rdata = opnd_cfg_r;
    if (stat_sel) rdata = {23'h000000, err_r, result_r};
    if (ores_sel) rdata = {19'h00000, eff_r};
  end
  assign prdata_o = rdata;

  // checks look one cycle after the edge that takes the request
  zero_flag_a: assert property (
    (res_wr && upd_z) |=> flags_r[csf_pkg::Z_BIT] == (result_o == 8'h00))
    else $error("zero flag mismatch");
  sign_flag_a: assert property (
    (res_wr && upd_szc) |=> flags_r[csf_pkg::S_BIT] == result_o[7])
    else $error("sign flag mismatch");
  logic_ovf_a: assert property (
    (op_valid_i && op inside {csf_pkg::and_op, csf_pkg::or_op,
      csf_pkg::xor_op, csf_pkg::com_op}) |=> !flags_r[csf_pkg::V_BIT])
    else $error("logic op left overflow set");
  add_ovf_a: assert property (
    (op_valid_i && op == csf_pkg::add_op && op_a_i == 8'h7F &&
      op_b_i == 8'h01) |=> flags_r[csf_pkg::V_BIT])
    else $error("overflow missed");
  inc_ovf_a: assert property (
    (op_valid_i && op == csf_pkg::inc_op && op_a_i == 8'h7F) |=>
      flags_r[csf_pkg::V_BIT] && result_o == 8'h80)
    else $error("increment overflow missed");
  add_carry_a: assert property (
    (op_valid_i && op == csf_pkg::add_op) |=>
      flags_r[csf_pkg::C_BIT] == $past(sum_w[8]))
    else $error("carry mismatch");
  shift_carry_a: assert property (
    (op_valid_i && op == csf_pkg::arith_right_shift_op) |=>
      flags_r[csf_pkg::C_BIT] == $past(op_a_i[0]))
    else $error("shift carry mismatch");
  rot_carry_a: assert property (
    (op_valid_i && op == csf_pkg::rotate_left_via_carry_op) |=>
      flags_r[csf_pkg::C_BIT] == $past(op_a_i[7]) &&
      result_o[0] == $past(flags_r[csf_pkg::C_BIT]))
    else $error("rotate carry mismatch");
  carry_only_a: assert property (
    (op_valid_i && op == csf_pkg::invert_carry_op) |=>
      flags_r[csf_pkg::Z_BIT:0] == $past(flags_r[csf_pkg::Z_BIT:0]) &&
      flags_r[csf_pkg::C_BIT] != $past(flags_r[csf_pkg::C_BIT]))
    else $error("carry op disturbed flags");
  jump_view_a: assert property (
    (apb_wr && flags_sel && !op_valid_i) |=>
      jump_flags_o == $past(pwdata_i[csf_pkg::C_BIT:csf_pkg::V_BIT]))
    else $error("jump flags wrong");
  load_write_a: assert property (
    load_wr |=> flags_r == $past(op_b_i))
    else $error("load did not write flags");
  work_reg_a: assert property (
    (mode_valid_i && !rel_i && mode_i == csf_pkg::work_reg_mode &&
      mode_field_i > 13'h000F) |=> mode_err_o)
    else $error("working register out of range accepted");
  pair_odd_a: assert property (
    (mode_valid_i && !rel_i && mode_i == csf_pkg::reg_pair_mode &&
      mode_field_i[0]) |=> mode_err_o)
    else $error("odd pair accepted");
  idx_addr_a: assert property (
    (mode_valid_i && !rel_i && mode_i == csf_pkg::indexed_mode) |=>
      eff_addr_o[7:0] == $past(8'(mode_field_i[7:0] + mode_reg_val_i[7:0])))
    else $error("indexed address wrong");
  short_idx_a: assert property (
    (mode_valid_i && !rel_i && mode_i == csf_pkg::short_index_mode) |=>
      eff_addr_o == $past(mode_reg_val_i[12:0] +
        13'(signed'(mode_field_i[7:0]))))
    else $error("short index address wrong");
  long_idx_a: assert property (
    (mode_valid_i && !rel_i && mode_i == csf_pkg::long_index_mode) |=>
      eff_addr_o == $past(mode_reg_val_i[12:0] + mode_field_i))
    else $error("long index address wrong");
  direct_tgt_a: assert property (
    (mode_valid_i && !rel_i && mode_i == csf_pkg::direct_target_mode) |=>
      eff_addr_o == $past(mode_field_i) && !mode_err_o)
    else $error("direct target wrong");
  rel_tgt_a: assert property (
    (mode_valid_i && rel_i) |=> eff_addr_o == $past(next_pc_i + sdisp))
    else $error("relative target wrong");
  cmp_cov_c: cover property (@(posedge ref_clk_i) op_valid_i &&
    op == csf_pkg::cp_op);
  add_cov_c: cover property (@(posedge ref_clk_i) op_valid_i &&
    op == csf_pkg::add_op && sum_w[8]);
  rot_cov_c: cover property (@(posedge ref_clk_i) op_valid_i &&
    op == csf_pkg::rotate_left_via_carry_op);
  apb_cov_c: cover property (@(posedge ref_clk_i) apb_wr && flags_sel);
  mode_cov_c: cover property (@(posedge ref_clk_i) mode_valid_i && err_n);
endmodule // csf_core

// ==== rtl/csf_pkg.sv ====
/*
  csf_pkg: register map, flag bit positions, operation and addressing-mode
  codes, and operand limits shared by the condition flag / operand block.
  assumes an 8-bit core with a 13-bit program/data address space.
*/
package csf_pkg;
  localparam logic [11:0] FLAGS_ADDR = 12'h0D5 << 2;
  localparam logic [11:0] OPND_ADDR = 12'h100;
  localparam logic [11:0] STAT_ADDR = 12'h104;
  localparam logic [11:0] OPND_RES_ADDR = 12'h108;
  localparam int V_BIT = 4;
  localparam int S_BIT = 5;
  localparam int Z_BIT = 6;
  localparam int C_BIT = 7;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [3:0] SREG_MASK = 4'hF;
  localparam logic [12:0] ADDR_MAX = 13'h1FFF;
  localparam int OP_W = 5;
  typedef enum logic [4:0] {
    add_op, adc_op, sub_op, sbc_op, cp_op, inc_op, dec_op,
    and_op, or_op, xor_op, com_op,
    test_under_mask_op, test_inverse_mask_op,
    rotate_left_op, rotate_right_op,
    rotate_left_via_carry_op, rotate_right_via_carry_op,
    arith_right_shift_op,
    set_carry_op, clear_carry_op, invert_carry_op,
    load_op
  } csf_op_e;
  typedef enum logic [2:0] {
    reg_mode, work_reg_mode, reg_pair_mode, work_pair_mode,
    indexed_mode, short_index_mode, long_index_mode, direct_target_mode
  } csf_mode_e;
  localparam logic [2:0] PC_OFFSET_MODE = 3'h0;
endpackage

// ==== verification/testbench.sv ====
/*
  testbench: self-checking bench for csf_core; flag arithmetic, carry
  operations, flag register over APB and operand range checks.
  assumes zero-wait APB slave and one-cycle registered op/mode outputs.
*/
`timescale 1ns/1ns
module testbench;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic psel_i, penable_i, pwrite_i, op_valid_i, mode_valid_i, rel_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, q;
  logic pready_o, pslverr_o, mode_err_o, e;
  logic [4:0] op_code_i;
  logic [7:0] op_a_i, op_b_i, result_o, ef, er, a, b;
  logic [3:0] jump_flags_o;
  logic [2:0] mode_i;
  logic [12:0] mode_field_i, next_pc_i, eff_addr_o, f13;
  logic [15:0] mode_reg_val_i, nx;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  csf_pkg::csf_op_e op;
  csf_pkg::csf_op_e tbl [21] = '{csf_pkg::add_op, csf_pkg::adc_op,
    csf_pkg::sub_op, csf_pkg::sbc_op, csf_pkg::cp_op, csf_pkg::and_op,
    csf_pkg::or_op, csf_pkg::xor_op, csf_pkg::com_op,
    csf_pkg::test_under_mask_op, csf_pkg::test_inverse_mask_op,
    csf_pkg::rotate_left_op, csf_pkg::rotate_right_op,
    csf_pkg::rotate_left_via_carry_op, csf_pkg::rotate_right_via_carry_op,
    csf_pkg::arith_right_shift_op, csf_pkg::set_carry_op,
    csf_pkg::clear_carry_op, csf_pkg::inc_op, csf_pkg::dec_op,
    csf_pkg::load_op};

  csf_core i_csf_core (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .op_valid_i(op_valid_i),
    .op_code_i(op_code_i), .op_a_i(op_a_i), .op_b_i(op_b_i),
    .result_o(result_o), .jump_flags_o(jump_flags_o),
    .mode_valid_i(mode_valid_i), .mode_i(mode_i),
    .mode_field_i(mode_field_i), .mode_reg_val_i(mode_reg_val_i),
    .next_pc_i(next_pc_i), .rel_i(rel_i), .eff_addr_o(eff_addr_o),
    .mode_err_o(mode_err_o));

  always #5 ref_clk_i = ~ref_clk_i;

  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // a hang anywhere ends up in the same report
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] ad,
                     input logic [31:0] d);
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= ad;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    // only the bench timeout ends a wait for the slave
    do begin
      @(posedge ref_clk_i);
    end while (pready_o !== 1'b1);
    // read data and response are taken at the completing edge
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  // expected {flags, result}; non-writing ops keep the old result
  function automatic logic [15:0] calc(input csf_pkg::csf_op_e o,
    input logic [7:0] x, input logic [7:0] y, input logic [7:0] f,
    input logic [7:0] rp);
    logic [8:0] w;
    logic [7:0] t;
    logic c, v, zs;
    t = 8'h00;
    c = f[7];
    v = 1'b0;
    zs = 1'b1;
    if (o == csf_pkg::load_op) return {y, rp};
    case (o)
      csf_pkg::add_op, csf_pkg::adc_op: begin
        w = {1'b0, x} + {1'b0, y} + {8'h00, (o == csf_pkg::adc_op) & f[7]};
        t = w[7:0];
        c = w[8];
        v = (x[7] == y[7]) && (t[7] != x[7]);
      end
      csf_pkg::sub_op, csf_pkg::sbc_op, csf_pkg::cp_op: begin
        w = {1'b0, x} - {1'b0, y} - {8'h00, (o == csf_pkg::sbc_op) & f[7]};
        t = w[7:0];
        c = w[8];
        v = (x[7] != y[7]) && (t[7] != x[7]);
      end
      csf_pkg::inc_op, csf_pkg::dec_op: begin
        t = (o == csf_pkg::inc_op) ? x + 8'h01 : x - 8'h01;
        v = (o == csf_pkg::inc_op) ? (x == 8'h7F) : (x == 8'h80);
      end
      csf_pkg::and_op: t = x & y;
      csf_pkg::or_op: t = x | y;
      csf_pkg::xor_op: t = x ^ y;
      csf_pkg::com_op: t = ~x;
      csf_pkg::test_under_mask_op: t = x & y;
      csf_pkg::test_inverse_mask_op: t = ~x & y;
      csf_pkg::rotate_left_op: {c, t} = {x[7], x[6:0], x[7]};
      csf_pkg::rotate_right_op: {c, t} = {x[0], x[0], x[7:1]};
      csf_pkg::rotate_left_via_carry_op: {c, t} = {x[7], x[6:0], f[7]};
      csf_pkg::rotate_right_via_carry_op: {c, t} = {x[0], f[7], x[7:1]};
      csf_pkg::arith_right_shift_op: {c, t} = {x[0], x[7], x[7:1]};
      default: begin
        zs = 1'b0;
        v = f[4];
        c = (o == csf_pkg::set_carry_op) ? 1'b1 :
            (o == csf_pkg::clear_carry_op) ? 1'b0 : ~f[7];
      end
    endcase
    if (o inside {csf_pkg::rotate_left_op, csf_pkg::rotate_right_op,
        csf_pkg::rotate_left_via_carry_op,
        csf_pkg::rotate_right_via_carry_op}) begin
      v = t[7] ^ x[7];
    end
    return {c, zs ? (t == 8'h00) : f[6], zs ? t[7] : f[5], v, f[3:0],
            (zs && !(o inside {csf_pkg::cp_op, csf_pkg::test_under_mask_op,
             csf_pkg::test_inverse_mask_op})) ? t : rp};
  endfunction

  task automatic run_op(input csf_pkg::csf_op_e o, input logic [7:0] x,
                        input logic [7:0] y);
    @(posedge ref_clk_i);
    op_valid_i <= 1'b1;
    op_code_i <= o;
    op_a_i <= x;
    op_b_i <= y;
    @(posedge ref_clk_i);
    op_valid_i <= 1'b0;
    #1;
    {ef, er} = calc(o, x, y, ef, er);
    chk(jump_flags_o[0], ef[csf_pkg::V_BIT]);
    chk(jump_flags_o[1], ef[csf_pkg::S_BIT]);
    chk(jump_flags_o[2], ef[csf_pkg::Z_BIT]);
    chk(jump_flags_o[3], ef[csf_pkg::C_BIT]);
    chk(result_o, er);
  endtask

  task automatic run_mode(input logic [2:0] m, input logic [12:0] fld,
                          input logic rl, input logic [12:0] pc);
    @(posedge ref_clk_i);
    mode_valid_i <= 1'b1;
    mode_i <= m;
    mode_field_i <= fld;
    rel_i <= rl;
    next_pc_i <= pc;
    mode_reg_val_i <= nx;
    @(posedge ref_clk_i);
    mode_valid_i <= 1'b0;
    #1;
  endtask

  initial begin
    {psel_i, penable_i, pwrite_i, op_valid_i, mode_valid_i, rel_i} = 6'h00;
    paddr_i = 12'h000;
    pwdata_i = 32'h00000000;
    op_code_i = 5'h00;
    {op_a_i, op_b_i} = 16'h0000;
    mode_i = 3'h0;
    {mode_field_i, next_pc_i} = 26'h0000000;
    mode_reg_val_i = 16'h0000;
    nx = 16'h0000;
    void'($urandom(77));
    repeat (12) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    apb(1'b0, csf_pkg::FLAGS_ADDR, 32'h0);
    chk(q, {24'h000000, csf_pkg::FLAGS_RST});
    apb(1'b0, 12'h200, 32'h0);
    chk({e, q}, {1'b1, 32'h00000000});
    apb(1'b1, csf_pkg::FLAGS_ADDR, 32'h0000005A);
    apb(1'b1, 12'h200, 32'h000000FF);
    #1;
    chk(jump_flags_o, 4'h5);
    apb(1'b0, csf_pkg::FLAGS_ADDR, 32'h0);
    chk(q, 32'h0000005A);
    ef = 8'h5A;
    er = 8'h00;
    // boundary cases of the signed range and of carry and borrow
    run_op(csf_pkg::add_op, 8'h7F, 8'h01);
    run_op(csf_pkg::add_op, 8'h80, 8'h80);
    run_op(csf_pkg::adc_op, 8'hFF, 8'h00);
    run_op(csf_pkg::sub_op, 8'h80, 8'h01);
    run_op(csf_pkg::sbc_op, 8'h00, 8'h00);
    run_op(csf_pkg::invert_carry_op, 8'h00, 8'h00);
    run_op(csf_pkg::and_op, 8'hF0, 8'h0F);
    run_op(csf_pkg::test_inverse_mask_op, 8'hFF, 8'hFF);
    run_op(csf_pkg::inc_op, 8'h7F, 8'h00);
    run_op(csf_pkg::dec_op, 8'h80, 8'h00);
    for (int i = 0; i < 400; i++) begin
      op = (i % 7 == 6) ? csf_pkg::invert_carry_op : tbl[$urandom % 21];
      a = 8'($urandom);
      b = (i % 5 == 0) ? a : 8'($urandom);
      run_op(op, a, b);
      if (i % 50 == 49) begin
        apb(1'b0, csf_pkg::FLAGS_ADDR, 32'h0);
        chk(q, {24'h000000, ef});
      end
    end
    // a second reset mid-run must bring flags and result back
    @(posedge ref_clk_i);
    rst_b_i <= 1'b0;
    @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    #1;
    chk({jump_flags_o, result_o}, {csf_pkg::FLAGS_RST[7:4], 8'h00});
    for (int i = 0; i < 20; i++) begin
      f13 = 13'($urandom);
      run_mode(csf_pkg::direct_target_mode, f13, 1'b0, 13'h0000);
      chk({mode_err_o, eff_addr_o}, {1'b0, f13});
      a = (i == 0) ? 8'h80 : (i == 1) ? 8'h7F : 8'($urandom);
      nx = {{8{a[7]}}, a};
      run_mode(csf_pkg::PC_OFFSET_MODE, {{5{a[7]}}, a}, 1'b1, f13);
      chk(eff_addr_o, 13'(f13 + nx[12:0]));
      nx = {3'h0, 13'($urandom)};
      run_mode(csf_pkg::indexed_mode, {5'h00, a}, 1'b0, 13'h0000);
      chk({mode_err_o, eff_addr_o}, {6'h00, 8'(a + nx[7:0])});
      run_mode(csf_pkg::short_index_mode, {5'h00, a}, 1'b0, 13'h0000);
      chk(eff_addr_o, 13'(nx[12:0] + {{5{a[7]}}, a}));
      run_mode(csf_pkg::long_index_mode, f13, 1'b0, 13'h0000);
      chk({mode_err_o, eff_addr_o}, {1'b0, 13'(nx[12:0] + f13)});
      run_mode(csf_pkg::work_pair_mode, 13'h0004, 1'b0, 13'h0000);
      chk({mode_err_o, eff_addr_o}, {1'b0, nx[12:0]});
    end
    run_mode(csf_pkg::reg_pair_mode, 13'h00FE, 1'b0, 13'h0000);
    chk(mode_err_o, 1'b0);
    run_mode(csf_pkg::reg_pair_mode, 13'h0033, 1'b0, 13'h0000);
    chk(mode_err_o, 1'b1);
    run_mode(csf_pkg::work_pair_mode, 13'h000E, 1'b0, 13'h0000);
    chk(mode_err_o, 1'b0);
    run_mode(csf_pkg::work_reg_mode, 13'h000F, 1'b0, 13'h0000);
    chk(mode_err_o, 1'b0);
    run_mode(csf_pkg::work_reg_mode, 13'h0010, 1'b0, 13'h0000);
    chk(mode_err_o, 1'b1);
    run_mode(csf_pkg::reg_mode, 13'h00FF, 1'b0, 13'h0000);
    chk({mode_err_o, eff_addr_o}, {1'b0, 13'h00FF});
    run_mode(csf_pkg::reg_mode, 13'h0100, 1'b0, 13'h0000);
    chk(mode_err_o, 1'b1);
    nx = 16'h8000;
    run_mode(csf_pkg::long_index_mode, 13'h0000, 1'b0, 13'h0000);
    chk(mode_err_o, 1'b1);
    end_sim();
  end
endmodule // testbench
